// File: logic/tcc_pkg.sv
// package for the channel c capture/compare pin control block
// assumes one 10 MHz clock and a synchronous active-high reset
package tcc_pkg;

  // field positions inside the 4-bit io control field
  localparam int ROLE_BIT   = 3;              // 0 compare, 1 capture
  localparam int LEVEL_BIT  = 2;              // compare initial level; set together with bit 3 is prohibited
  localparam int ACT_HI_BIT = 1;
  localparam int ACT_LO_BIT = 0;

  // compare actions held in the low two bits
  localparam logic [1:0] ACT_OFF    = 2'h0;  // pin disabled
  localparam logic [1:0] ACT_LOW    = 2'h1;  // drive low on match
  localparam logic [1:0] ACT_HIGH   = 2'h2;  // drive high on match
  localparam logic [1:0] ACT_TOGGLE = 2'h3;  // invert on match

  // capture edge selects, upper three bits
  localparam logic [2:0] CAP_RISE = 3'h4;    // with bit0 = 0
  localparam logic [2:0] CAP_BOTH = 3'h5;    // bit0 ignored

  localparam int  CNT_WIDTH = 16;            // counter and register width
  localparam logic [CNT_WIDTH-1:0] GRC_RESET = 16'hFFFF;
  localparam logic [3:0] IOC_RESET = 4'h0;

  // control bits gathered into one carrier
  typedef struct packed
  {
    logic       bufferSelect;               // register c used as buffer
    logic [3:0] ioCtrl;                     // channel0_io_control_low
  } tcc_ctrl_s;

  // per-cycle event flags reported to the outside
  typedef struct packed
  {
    logic compareMatch;                     // one-cycle pulse
    logic captureDone;                      // one-cycle pulse
  } tcc_event_s;

endpackage : tcc_pkg

// File: logic/tcc_edge_sync.sv
// two-flop synchroniser plus edge detector for the channel c pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module tcc_edge_sync
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic pinIn,
  output logic      riseEdge,
  output logic      fallEdge
);

  logic meta_reg, meta_next;     // first stage, read only by sync stage
  logic sync_reg, sync_next;     // second stage
  logic prev_reg, prev_next;     // delayed copy for edge detection

  // next-state of the synchroniser chain
  always_comb
  begin
    meta_next = pinIn;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // registers; reset to low so no false edge from a low pin
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // edges seen only past the second stage
  assign riseEdge = sync_reg & ~prev_reg;
  assign fallEdge = ~sync_reg & prev_reg;

endmodule : tcc_edge_sync
`default_nettype wire

// File: logic/tcc_channel_c.sv
// channel c capture/compare register and pin control
// assumes the counter comes from logic on sys_clk; the pin input is asynchronous
`timescale 1ns/100ps
`default_nettype none

// What this block does
// RL1: bit 3 selects compare or capture role
// RL2: compare 00 disables pin; bit2 sets initial
// RL3: compare 01 drives pin low on match
// RL4: compare 10 drives pin high on match
// RL5: compare 11 toggles pin on match
// RL6: capture source is the channel pin only
// RL7: setting 1000 captures on rising edge
// RL8: setting 1001 captures on falling edge
// RL9: setting 101x captures on both edges
// RL10: software never sets both top bits
// RL11: buffer mode suppresses matches and captures
// RL12: capture copies counter; match when equal
module tcc_channel_c
#(
  parameter int W = tcc_pkg::CNT_WIDTH     // counter width
)
(
  input  wire logic            sys_clk,
  input  wire logic            srst,
  input  wire tcc_pkg::tcc_ctrl_s ctrl,    // control field and buffer select
  input  wire logic [W-1:0]    counter,    // channel counter value
  input  wire logic            grcWrite,   // software write strobe for register c
  input  wire logic [W-1:0]    grcWriteData,
  input  wire logic            pinIn,      // channel_c_pin input side
  output logic                 pinOut,     // channel_c_pin output level
  output logic                 pinOe_n,    // low while the block drives the pin
  output logic [W-1:0]         generalRegC,
  output tcc_pkg::tcc_event_s  events
);

  logic [W-1:0] grc_reg, grc_next;         // general_reg_c
  logic         out_reg, out_next;         // pin level
  logic         oe_n_reg, oe_n_next;       // pin enable, active low
  logic [3:0]   ioc_reg;                   // last applied control field
  logic [3:0]   ioc_next;
  logic         match_reg, match_next;     // match event pulse
  logic         cap_reg, cap_next;         // capture event pulse
  logic         riseEdge;
  logic         fallEdge;

  // decoded control
  logic         isCapture;
  logic         illegal;
  logic         active;
  logic [1:0]   action;
  logic         captureHit;
  logic         compareHit;
  logic         cfgChanged;

  // pin synchroniser and edge detector
  tcc_edge_sync u_sync
  (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .pinIn    (pinIn),                     // RL6
    .riseEdge (riseEdge),
    .fallEdge (fallEdge)
  );

  // decode of the io control field
  always_comb
  begin
    isCapture  = ctrl.ioCtrl[tcc_pkg::ROLE_BIT];                                   // RL1
    // prohibited 11xx: nothing happens, pin left released
    illegal    = ctrl.ioCtrl[tcc_pkg::ROLE_BIT] & ctrl.ioCtrl[tcc_pkg::LEVEL_BIT]; // RL10
    active     = ~ctrl.bufferSelect & ~illegal;                                    // RL11
    action     = ctrl.ioCtrl[tcc_pkg::ACT_HI_BIT:tcc_pkg::ACT_LO_BIT];
    cfgChanged = ctrl.ioCtrl != ioc_reg;
    // capture edge choice
    captureHit = 1'b0;
    if (active && isCapture)
    begin
      if (ctrl.ioCtrl[tcc_pkg::ROLE_BIT:tcc_pkg::ACT_HI_BIT] == tcc_pkg::CAP_BOTH)
      begin
        captureHit = riseEdge | fallEdge;                                         // RL9
      end
      else if (ctrl.ioCtrl[tcc_pkg::ACT_LO_BIT])
      begin
        captureHit = fallEdge;                                                    // RL8
      end
      else
      begin
        captureHit = riseEdge;                                                    // RL7
      end
    end
    // compare only counts while the pin function is enabled
    compareHit = active & ~isCapture & (action != tcc_pkg::ACT_OFF) & (counter == grc_reg); // RL12
  end

  // next values of register c, pin and events
  always_comb
  begin
    grc_next   = grc_reg;
    out_next   = out_reg;
    oe_n_next  = oe_n_reg;
    ioc_next   = ctrl.ioCtrl;
    match_next = compareHit;
    cap_next   = captureHit;
    // capture wins over a software write in the same cycle
    if (captureHit)
    begin
      grc_next = counter;                                                         // RL12
    end
    else if (grcWrite)
    begin
      grc_next = grcWriteData;
    end
    // pin driver follows the compare setting
    if (ctrl.bufferSelect || isCapture || illegal || action == tcc_pkg::ACT_OFF)
    begin
      oe_n_next = 1'b1;                                                           // RL2
    end
    else
    begin
      oe_n_next = 1'b0;
      if (cfgChanged || oe_n_reg)
      begin
        // new setting: load the initial level first
        out_next = ctrl.ioCtrl[tcc_pkg::LEVEL_BIT];                               // RL2
      end
      else if (compareHit)
      begin
        unique case (action)
          tcc_pkg::ACT_LOW:    out_next = 1'b0;                                   // RL3
          tcc_pkg::ACT_HIGH:   out_next = 1'b1;                                   // RL4
          tcc_pkg::ACT_TOGGLE: out_next = ~out_reg;                               // RL5
          default:             out_next = out_reg;
        endcase
      end
    end
  end

  // registers only
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      grc_reg   <= tcc_pkg::GRC_RESET;
      out_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
      ioc_reg   <= tcc_pkg::IOC_RESET;
      match_reg <= 1'b0;
      cap_reg   <= 1'b0;
    end
    else
    begin
      grc_reg   <= grc_next;
      out_reg   <= out_next;
      oe_n_reg  <= oe_n_next;
      ioc_reg   <= ioc_next;
      match_reg <= match_next;
      cap_reg   <= cap_next;
    end
  end

  assign pinOut              = out_reg;
  assign pinOe_n             = oe_n_reg;
  assign generalRegC         = grc_reg;
  assign events.compareMatch = match_reg;
  assign events.captureDone  = cap_reg;

endmodule : tcc_channel_c
`default_nettype wire

// File: testbench/tcc_channel_c_properties.sv
// checker for the channel c pin control block
// assumes one clock and the synchronous reset of the block
`timescale 1ns/100ps
`default_nettype none
module tcc_channel_c_properties
#(parameter int W = 16)
(
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire tcc_pkg::tcc_ctrl_s  ctrl,
  input wire logic [W-1:0]        counter,
  input wire logic                pinIn,
  input wire logic                pinOut,
  input wire logic                pinOe_n,
  input wire logic [W-1:0]        generalRegC,
  input wire tcc_pkg::tcc_event_s events
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // settled compare setting meeting register c; a fresh setting only loads the initial level
  sequence match_s(logic [1:0] a);
    !$past(srst) && !ctrl.bufferSelect && !ctrl.ioCtrl[3] && ctrl.ioCtrl[1:0] == a && $stable(ctrl)
      && counter == generalRegC;
  endsequence
  low_match_a: assert property (match_s(2'h1) |=> !pinOut && events.compareMatch) else $error("no low");
  high_match_a: assert property (match_s(2'h2) |=> pinOut && events.compareMatch) else $error("no high");
  toggle_match_a: assert property (match_s(2'h3) |=> pinOut != $past(pinOut)) else $error("no toggle");
  capture_released_a: assert property (ctrl.ioCtrl[3] |=> pinOe_n && !events.compareMatch) else $error("pin");
  buffer_quiet_a: assert property (ctrl.bufferSelect |=> pinOe_n && events == 2'h0) else $error("buffer");
  rise_capture_a: assert property ($rose(pinIn) && ctrl == 5'h08 |-> ##[2:4] events.captureDone) else $error("rise");
  fall_capture_a: assert property ($fell(pinIn) && ctrl == 5'h09 |-> ##[2:4] events.captureDone) else $error("fall");
  both_capture_a: assert property ($changed(pinIn) && ctrl[4:1] == 4'h5 |-> ##[2:4] events.captureDone) else $error("both");
  capture_value_a: assert property (events.captureDone |-> generalRegC == $past(counter)) else $error("value");
endmodule : tcc_channel_c_properties
bind tcc_channel_c tcc_channel_c_properties #(.W(W)) chk_u (.sys_clk(sys_clk), .srst(srst), .ctrl(ctrl),
  .counter(counter), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .generalRegC(generalRegC), .events(events));
`default_nettype wire

// File: testbench/tcc_pin_source.sv
// signal source standing on the channel c pin
// assumes the block releases the pin by raising pinOe_n
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_source
(
  input  wire logic pinOut,   // block drive level
  input  wire logic pinOe_n,  // low while block drives
  input  wire logic srcLevel, // level the source wants
  output logic      pinLevel  // resolved wire level
);
  // released pin follows the source, driven pin the block
  assign pinLevel = pinOe_n ? srcLevel : pinOut;
endmodule : tcc_pin_source
`default_nettype wire

// File: testbench/tcc_channel_c_tb.sv
// testbench for the channel c pin control block
// assumes the checker is bound in by its own file
`timescale 1ns/100ps
`default_nettype none
module tcc_channel_c_tb;
  logic sys_clk = 1'b0, srst = 1'b1, grcWrite = 1'b0, srcLevel = 1'b0, pinLevel, pinOut, pinOe_n;
  logic [15:0] counter = 16'h0000, grcWriteData = 16'h0000, generalRegC;
  tcc_pkg::tcc_ctrl_s  ctrl = 5'h00;
  tcc_pkg::tcc_event_s events;
  int n_fail = 0, comparisons = 0, hits;
  logic [4:0] modes [5] = '{5'h08, 5'h09, 5'h0B, 5'h18, 5'h0C}; // rise, fall, both, buffer, prohibited 11xx
  int edgeCnt [5] = '{1, 1, 2, 0, 0};
  logic [4:0] cmps [4] = '{5'h05, 5'h02, 5'h03, 5'h07}; // low, high, toggle from 0 and from 1
  logic afterLvl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  always #50 sys_clk = ~sys_clk;
  // free-running counter as the channel timebase
  always @(posedge sys_clk) counter <= counter + 16'h0001;
  tcc_channel_c #(.W(16)) dut_u (.sys_clk(sys_clk), .srst(srst), .ctrl(ctrl), .counter(counter), .grcWrite(grcWrite),
    .grcWriteData(grcWriteData), .pinIn(pinLevel), .pinOut(pinOut), .pinOe_n(pinOe_n), .generalRegC(generalRegC),
    .events(events));
  tcc_pin_source src_u (.pinOut(pinOut), .pinOe_n(pinOe_n), .srcLevel(srcLevel), .pinLevel(pinLevel));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // watchdog, the tests need well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    check(pinOe_n, 1'b1);
    check(generalRegC, 16'hFFFF);
    // each compare action: initial level, then level after the match
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      ctrl <= 5'h00;
      grcWrite <= 1'b1;
      grcWriteData <= counter + 16'h0010;
      @(posedge sys_clk);
      grcWrite <= 1'b0;
      ctrl <= cmps[i];
      repeat (2) @(negedge sys_clk);
      check(pinOe_n, 1'b0);
      check(pinOut, cmps[i][2]);
      for (int t = 0; t < 30 && events.compareMatch !== 1'b1; t++) @(negedge sys_clk);
      check(events.compareMatch, 1'b1);
      check(pinOut, afterLvl[i]);
    end
    $display("compare tests done");
    // each capture setting: one rise and one fall on the pin, count captures
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      ctrl <= modes[i];
      hits = 0;
      for (int t = 0; t < 16; t++)
      begin
        @(posedge sys_clk);
        srcLevel <= (t < 8);
        @(negedge sys_clk);
        if (events.captureDone === 1'b1)
        begin
          hits++;
          check(generalRegC, counter - 16'h0001);
        end
      end
      check(16'(hits), 16'(edgeCnt[i]));
      check(pinOe_n, 1'b1);
    end
    $display("capture tests done");
    give_verdict();
  end
endmodule : tcc_channel_c_tb
`default_nettype wire
